// ---- core/gpclip_map.svh ----
`ifndef GPCLIP_MAP_SVH
`define GPCLIP_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GPCLIP_OFS_INT_MODE 8'h28
`define GPCLIP_OFS_INT_UNMASK 8'h29
`define GPCLIP_OFS_INT_STATUS 8'h2a
`define GPCLIP_OFS_CLIP_FLAGS 8'h2b
`define GPCLIP_OFS_PIN_DIR 8'h2c
`define GPCLIP_OFS_PIN_POL 8'h2d
`define GPCLIP_OFS_PIN_TRIG 8'h2e
`define GPCLIP_OFS_PIN_STATE 8'h2f
`define GPCLIP_OFS_PIN_UNMASK 8'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GPCLIP_POS_CLIP_TRIG 0
`define GPCLIP_POS_STYLE_LO 6
`define GPCLIP_POS_STYLE_HI 7
`define GPCLIP_POS_GPIO_SUM 1
`define GPCLIP_POS_CLIP_SUM 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GPCLIP_RST_PIN_DIR 7'h00
`define GPCLIP_RST_PIN_POL 7'h7f
`define GPCLIP_RST_PIN_TRIG 7'h00
`define GPCLIP_RST_PIN_UNMASK 4'h0
`define GPCLIP_RST_CLIP_FLAGS 8'h00
`define GPCLIP_RST_INT_UNMASK 8'h00

`endif

// ---- core/gpclip_pkg.sv ----
package gpclip_pkg;

   typedef logic [6:0] gpclip_pins_type;
   typedef logic [7:0] gpclip_byte_type;

   typedef enum logic [1:0] {
      gpclip_style_high = 2'b00,
      gpclip_style_low = 2'b01,
      gpclip_style_drain = 2'b10,
      gpclip_style_rsvd = 2'b11
   } gpclip_style_type;

endpackage

// ---- core/gpclip_core.sv ----
`timescale 1ns/1ps
`include "gpclip_map.svh"

// Behaviour
// - GPIO summary bit is OR of unmasked input pin status bits.
// - Reading interrupt status keeps GPIO interrupt; only pin status read removes it.
// - Edge inputs cleared by status read; level inputs hold while active.
// - Eight sticky clip flags, channel A1 at bit 0 to B4 at bit 7.
// - Clip flag read clears all flags only in edge mode.
// - Clip flags record events whatever the clip unmask bit says.
// - A saturated output sample sets its channel clip flag.
// - Per-pin direction bit, 0 input, 1 output, resets to input.
// - Input polarity bit, 0 active low, 1 active high, resets to 1.
// - Output type from same bit, 0 push-pull, 1 open-drain.
// - Input trigger bit, 0 level, 1 edge; ignored for outputs.
// - Edge status latches transition; cleared by status read or reset.
// - Level status is never cleared by read; follows the pin.
// - Unmask bits never affect status bits, only interrupt propagation.
// - Interrupt status read leaves every pin status bit unchanged.
// - Output pins driven from written status bits; input status is read-only.
// - Only pins 0 to 3 have unmask bits; 1 unmasks; reset 0.
// - Clip trigger select bit, 0 level, 1 edge, resets to level.
// - Level-mode summaries hold while active; read clears once level gone.
// - Request pin style: 00 high, 01 low, 10 open-drain low.
module gpclip_core (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Host control register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Clip events from output datapath
   input wire logic [7:0] clip_sample_event,
   // General purpose pins
   input wire logic [6:0] pin_in,
   output logic [6:0] pin_out,
   output logic [6:0] pin_oe,
   // Interrupt request pin
   output logic int_out,
   output logic int_oe
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   gpclip_pkg::gpclip_pins_type pin_direction;
   gpclip_pkg::gpclip_pins_type pin_polarity_type;
   gpclip_pkg::gpclip_pins_type pin_trigger_select;
   gpclip_pkg::gpclip_pins_type out_level;
   gpclip_pkg::gpclip_pins_type edge_flag;
   gpclip_pkg::gpclip_pins_type sync_a;
   gpclip_pkg::gpclip_pins_type sync_b;
   gpclip_pkg::gpclip_pins_type active_d;
   logic [3:0] pin_event_unmask;
   gpclip_pkg::gpclip_byte_type channel_clip_flags;
   gpclip_pkg::gpclip_byte_type int_unmask;
   gpclip_pkg::gpclip_style_type request_pin_style;
   logic clip_trigger_select;
   logic gpio_sum;
   logic clip_event_summary;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic rd_state;
   logic rd_clip;
   logic rd_isr;
   gpclip_pkg::gpclip_pins_type active;
   gpclip_pkg::gpclip_pins_type edge_set;
   gpclip_pkg::gpclip_pins_type next_edge_flag;
   gpclip_pkg::gpclip_pins_type next_status;
   gpclip_pkg::gpclip_pins_type status_view;
   logic next_gpio_any;
   logic request;

   assign rd_state = reg_rd && (reg_addr == `GPCLIP_OFS_PIN_STATE);
   assign rd_clip = reg_rd && (reg_addr == `GPCLIP_OFS_CLIP_FLAGS);
   assign rd_isr = reg_rd && (reg_addr == `GPCLIP_OFS_INT_STATUS);

   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sync_a <= 7'h00;
         sync_b <= 7'h00;
         active_d <= 7'h00;
      end else begin
         sync_a <= pin_in;
         sync_b <= sync_a;
         active_d <= active;
      end
   end

   // Polarity folded in after the second stage only
   assign active = ~(sync_b ^ pin_polarity_type);

   // ----------------------------------------
   // Pin status
   // ----------------------------------------
   // Polarity change may look like an edge; software should clear after it
   always_comb begin
      edge_set = active & ~active_d & pin_trigger_select & ~pin_direction;
      next_edge_flag = edge_set | (edge_flag & ~{7{rd_state}});
      next_status = 7'h00;
      for (int i = 0; i < 7; i++) begin
         next_status[i] = pin_trigger_select[i] ? next_edge_flag[i] : active[i];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         edge_flag <= 7'h00;
      end else begin
         edge_flag <= next_edge_flag;
      end
   end

   always_comb begin
      status_view = 7'h00;
      for (int i = 0; i < 7; i++) begin
         if (pin_direction[i]) begin
            status_view[i] = out_level[i];
         end else if (pin_trigger_select[i]) begin
            status_view[i] = edge_flag[i];
         end else begin
            status_view[i] = active[i];
         end
      end
   end

   // ----------------------------------------
   // GPIO summary
   // ----------------------------------------
   assign next_gpio_any = |(pin_event_unmask & ~pin_direction[3:0] & next_status[3:0]);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         gpio_sum <= 1'b0;
      end else begin
         // Set wins over the read; level pins still active keep it up
         gpio_sum <= next_gpio_any | (gpio_sum & ~rd_state);
      end
   end

   // ----------------------------------------
   // Clip flags
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         channel_clip_flags <= `GPCLIP_RST_CLIP_FLAGS;
      end else if (rd_clip && clip_trigger_select) begin
         channel_clip_flags <= clip_sample_event;
      end else begin
         channel_clip_flags <= channel_clip_flags | clip_sample_event;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         clip_event_summary <= 1'b0;
      end else if (|clip_sample_event) begin
         clip_event_summary <= 1'b1;
      end else if (rd_clip) begin
         // Level mode clears here only because no event is present now
         clip_event_summary <= 1'b0;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pin_direction <= `GPCLIP_RST_PIN_DIR;
         pin_polarity_type <= `GPCLIP_RST_PIN_POL;
         pin_trigger_select <= `GPCLIP_RST_PIN_TRIG;
         pin_event_unmask <= `GPCLIP_RST_PIN_UNMASK;
      end else if (reg_wr) begin
         case (reg_addr)
            `GPCLIP_OFS_PIN_DIR: pin_direction <= reg_wdata[6:0];
            `GPCLIP_OFS_PIN_POL: pin_polarity_type <= reg_wdata[6:0];
            `GPCLIP_OFS_PIN_TRIG: pin_trigger_select <= reg_wdata[6:0];
            `GPCLIP_OFS_PIN_UNMASK: pin_event_unmask <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         out_level <= 7'h00;
      end else if (reg_wr && (reg_addr == `GPCLIP_OFS_PIN_STATE)) begin
         // Input bits are read-only, so only output bits take the write
         out_level <= (reg_wdata[6:0] & pin_direction) | (out_level & ~pin_direction);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         request_pin_style <= gpclip_pkg::gpclip_style_high;
         clip_trigger_select <= 1'b0;
         int_unmask <= `GPCLIP_RST_INT_UNMASK;
      end else if (reg_wr && (reg_addr == `GPCLIP_OFS_INT_MODE)) begin
         request_pin_style <= gpclip_pkg::gpclip_style_type'(
            reg_wdata[`GPCLIP_POS_STYLE_HI:`GPCLIP_POS_STYLE_LO]);
         clip_trigger_select <= reg_wdata[`GPCLIP_POS_CLIP_TRIG];
      end else if (reg_wr && (reg_addr == `GPCLIP_OFS_INT_UNMASK)) begin
         int_unmask <= reg_wdata;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               `GPCLIP_OFS_INT_MODE: reg_rdata <= {request_pin_style, 5'h00, clip_trigger_select};
               `GPCLIP_OFS_INT_UNMASK: reg_rdata <= int_unmask;
               `GPCLIP_OFS_INT_STATUS: reg_rdata <= {5'h00, clip_event_summary,
                  gpio_sum, 1'b0};
               `GPCLIP_OFS_CLIP_FLAGS: reg_rdata <= channel_clip_flags;
               `GPCLIP_OFS_PIN_DIR: reg_rdata <= {1'b0, pin_direction};
               `GPCLIP_OFS_PIN_POL: reg_rdata <= {1'b0, pin_polarity_type};
               `GPCLIP_OFS_PIN_TRIG: reg_rdata <= {1'b0, pin_trigger_select};
               `GPCLIP_OFS_PIN_STATE: reg_rdata <= {1'b0, status_view};
               `GPCLIP_OFS_PIN_UNMASK: reg_rdata <= {4'h0, pin_event_unmask};
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pin_out <= 7'h00;
         pin_oe <= 7'h00;
      end else begin
         for (int i = 0; i < 7; i++) begin
            if (!pin_direction[i]) begin
               pin_out[i] <= 1'b0;
               pin_oe[i] <= 1'b0;
            end else if (pin_polarity_type[i]) begin
               pin_out[i] <= 1'b0;
               pin_oe[i] <= ~out_level[i];
            end else begin
               pin_out[i] <= out_level[i];
               pin_oe[i] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Interrupt pin
   // ----------------------------------------
   assign request = gpio_sum | (clip_event_summary & int_unmask[`GPCLIP_POS_CLIP_SUM]);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         int_out <= 1'b0;
         int_oe <= 1'b0;
      end else begin
         case (request_pin_style)
            gpclip_pkg::gpclip_style_high: begin
               int_out <= request;
               int_oe <= 1'b1;
            end
            gpclip_pkg::gpclip_style_low: begin
               int_out <= ~request;
               int_oe <= 1'b1;
            end
            gpclip_pkg::gpclip_style_drain: begin
               int_out <= 1'b0;
               int_oe <= request;
            end
            default: begin
               // Reserved code: pin left undriven
               int_out <= 1'b0;
               int_oe <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   property p_summary_set;
      next_gpio_any |=> gpio_sum;
   endproperty
   a_summary_set: assert property (p_summary_set)
      else $error("gpio summary not set");
   property p_isr_keeps;
      (rd_isr && !(|edge_set)) |=> ($stable(edge_flag) && gpio_sum >= $past(gpio_sum));
   endproperty
   a_isr_keeps: assert property (p_isr_keeps)
      else $error("status read disturbed pin status");
   property p_edge_clear;
      (rd_state && edge_set == 7'h00) |=> (edge_flag == 7'h00);
   endproperty
   a_edge_clear: assert property (p_edge_clear)
      else $error("edge status not cleared by read");
   property p_clip_edge_clear;
      (rd_clip && clip_trigger_select && !(|clip_sample_event)) |=> channel_clip_flags == 8'h00;
   endproperty
   a_clip_edge_clear: assert property (p_clip_edge_clear)
      else $error("clip flags not cleared in edge mode");
   property p_clip_level_keep;
      (rd_clip && !clip_trigger_select) |=>
         channel_clip_flags == ($past(channel_clip_flags) | $past(clip_sample_event));
   endproperty
   a_clip_level_keep: assert property (p_clip_level_keep)
      else $error("clip flags changed by level mode read");
   property p_clip_set;
      (|clip_sample_event) |=> &(channel_clip_flags | ~$past(clip_sample_event));
   endproperty
   a_clip_set: assert property (p_clip_set)
      else $error("clip flag missed event");
   property p_push_pull;
      pin_direction[0] && !pin_polarity_type[0] |=> pin_oe[0] && pin_out[0] == $past(out_level[0]);
   endproperty
   a_push_pull: assert property (p_push_pull)
      else $error("push-pull output wrong");
   property p_open_drain;
      pin_direction[0] && pin_polarity_type[0] |=> !pin_out[0] && pin_oe[0] != $past(out_level[0]);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("open-drain output wrong");
   property p_input_idle;
      (pin_direction == 7'h00) |=> (pin_oe == 7'h00);
   endproperty
   a_input_idle: assert property (p_input_idle)
      else $error("input pin driven");
   property p_style_low;
      (request_pin_style == gpclip_pkg::gpclip_style_low && request) |=> (int_oe && !int_out);
   endproperty
   a_style_low: assert property (p_style_low)
      else $error("active low request pin wrong");

   c_edge_read: cover property (edge_set[0] ##[1:20] rd_state);
   c_clip_edge: cover property (clip_trigger_select && rd_clip && channel_clip_flags != 8'h00);
   c_drain_req: cover property (request_pin_style == gpclip_pkg::gpclip_style_drain && int_oe);

endmodule

// ---- dv/gpclip_stage_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Far-side pin and power stage model
// ----------------------------------------
module gpclip_stage_model (
   // Device pin drive
   input wire logic [6:0] pin_out,
   input wire logic [6:0] pin_oe,
   input wire logic int_out,
   input wire logic int_oe,
   // External source drive
   input wire logic [6:0] ext_en,
   input wire logic [6:0] ext_val,
   // Resolved wire levels
   output logic [6:0] pin_level,
   output logic int_level
);
   // Pull-ups hold released lines high, so open drain reads back high
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         pin_level[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
      int_level = int_oe ? int_out : 1'b1;
   end
endmodule

// ---- dv/gpio_and_clip_status_logic_test.sv ----
`timescale 1ns/1ps
`include "gpclip_map.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module gpio_and_clip_status_logic_test;
   // ----------------------------------------
   // Stimulus and observation
   // ----------------------------------------
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic [7:0] clip_sample_event = 8'h00;
   logic [6:0] ext_en = 7'h00;
   logic [6:0] ext_val = 7'h00;
   logic [6:0] pin_level;
   logic [6:0] pin_out;
   logic [6:0] pin_oe;
   logic int_out;
   logic int_oe;
   logic int_level;
   logic [7:0] rd_val;
   logic [7:0] ev;
   logic [7:0] exp_flags = 8'h00;
   logic [7:0] expv;
   logic [6:0] v;
   logic [6:0] pol;
   logic [1:0] style;
   logic req;
   int num_errors = 0;
   int checked = 0;

   always #5 clk_sys = ~clk_sys;

   gpclip_core dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .clip_sample_event(clip_sample_event), .pin_in(pin_level), .pin_out(pin_out),
      .pin_oe(pin_oe), .int_out(int_out), .int_oe(int_oe));

   gpclip_stage_model far_side (.pin_out(pin_out), .pin_oe(pin_oe), .int_out(int_out),
      .int_oe(int_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level),
      .int_level(int_level));

   // ----------------------------------------
   // Bus tasks and expectations
   // ----------------------------------------
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask

   // Answer is registered, so sample one and a half cycles after the taking edge
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      `CHK(reg_rvalid, 1'b1)
      @(negedge clk_sys);
      `CHK(reg_rvalid, 1'b0)
      d = reg_rdata;
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   function automatic logic exp_int_level(input logic [1:0] s, input logic r);
      exp_int_level = (s == 2'b11) ? 1'b1 : ((s == 2'b00) ? r : ~r);
   endfunction

   function automatic logic [7:0] exp_level_state(input logic [6:0] lvl, input logic [6:0] p);
      exp_level_state = {1'b0, ~(lvl ^ p)};
   endfunction

   task automatic end_of_test();
      $display("errors %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      end_of_test();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(40451));
      repeat (6) @(negedge clk_sys);
      nrst = 1'b1;
      reg_read(`GPCLIP_OFS_PIN_DIR, rd_val); `CHK(rd_val, 8'h00)
      reg_read(`GPCLIP_OFS_PIN_POL, rd_val); `CHK(rd_val, 8'h7f)
      reg_read(`GPCLIP_OFS_PIN_TRIG, rd_val); `CHK(rd_val, 8'h00)
      reg_read(`GPCLIP_OFS_PIN_UNMASK, rd_val); `CHK(rd_val, 8'h00)
      reg_read(`GPCLIP_OFS_INT_MODE, rd_val); `CHK(rd_val, 8'h00)
      reg_read(`GPCLIP_OFS_CLIP_FLAGS, rd_val); `CHK(rd_val, 8'h00)
      // Clip flags: level mode first, then edge mode twice, the second with every channel at once
      for (int k = 0; k < 3; k++) begin
         reg_write(`GPCLIP_OFS_INT_MODE, {7'h00, k > 0});
         expv = 8'($urandom);
         reg_write(`GPCLIP_OFS_INT_UNMASK, expv);
         ev = (k == 2) ? 8'hff : 8'($urandom_range(1, 255));
         @(negedge clk_sys);
         clip_sample_event = ev;
         @(negedge clk_sys);
         clip_sample_event = 8'h00;
         exp_flags = exp_flags | ev;
         reg_read(`GPCLIP_OFS_INT_STATUS, rd_val); `CHK(rd_val[2], 1'b1)
         `CHK(int_level, expv[2])
         reg_read(`GPCLIP_OFS_CLIP_FLAGS, rd_val); `CHK(rd_val, exp_flags)
         if (k > 0) begin
            exp_flags = 8'h00;
         end
         reg_read(`GPCLIP_OFS_CLIP_FLAGS, rd_val); `CHK(rd_val, exp_flags)
         reg_read(`GPCLIP_OFS_INT_STATUS, rd_val); `CHK(rd_val[2], 1'b0)
      end
      // Level inputs under every pin style, masked and unmasked
      ext_en = 7'h7f;
      for (int k = 0; k < 8; k++) begin
         v = 7'($urandom);
         pol = (k < 2) ? 7'h7f : 7'($urandom);
         style = 2'(k >> 1);
         ext_val = v;
         reg_write(`GPCLIP_OFS_PIN_POL, {1'b0, pol});
         reg_write(`GPCLIP_OFS_PIN_UNMASK, k[0] ? 8'h0f : 8'h00);
         reg_write(`GPCLIP_OFS_INT_MODE, {style, 6'h00});
         reg_write(`GPCLIP_OFS_PIN_STATE, 8'($urandom));
         settle(6);
         expv = exp_level_state(v, pol);
         req = k[0] & (|expv[3:0]);
         reg_read(`GPCLIP_OFS_PIN_STATE, rd_val); `CHK(rd_val, expv)
         reg_read(`GPCLIP_OFS_PIN_STATE, rd_val); `CHK(rd_val, expv)
         reg_read(`GPCLIP_OFS_INT_STATUS, rd_val); `CHK(rd_val[1], req)
         `CHK(int_level, exp_int_level(style, req))
      end
      // Edge inputs: rising transitions latch, falls do not
      reg_write(`GPCLIP_OFS_PIN_POL, 8'h7f);
      reg_write(`GPCLIP_OFS_PIN_UNMASK, 8'h0f);
      reg_write(`GPCLIP_OFS_PIN_TRIG, 8'h7f);
      ext_val = 7'h00;
      settle(6);
      reg_read(`GPCLIP_OFS_PIN_STATE, rd_val);
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 7'h7f : 7'($urandom);
         ext_val = v;
         settle(6);
         reg_read(`GPCLIP_OFS_INT_STATUS, rd_val); `CHK(rd_val[1], |v[3:0])
         reg_read(`GPCLIP_OFS_INT_STATUS, rd_val); `CHK(rd_val[1], |v[3:0])
         reg_read(`GPCLIP_OFS_PIN_STATE, rd_val); `CHK(rd_val, {1'b0, v})
         reg_read(`GPCLIP_OFS_PIN_STATE, rd_val); `CHK(rd_val, 8'h00)
         reg_read(`GPCLIP_OFS_INT_STATUS, rd_val); `CHK(rd_val[1], 1'b0)
         ext_val = 7'h00;
         settle(6);
      end
      // Outputs, push-pull and open drain; the far side lets go of the pins
      ext_en = 7'h00;
      reg_write(`GPCLIP_OFS_PIN_DIR, 8'h7f);
      for (int k = 0; k < 4; k++) begin
         v = 7'($urandom);
         reg_write(`GPCLIP_OFS_PIN_POL, k[0] ? 8'h7f : 8'h00);
         reg_write(`GPCLIP_OFS_PIN_STATE, {1'b0, v});
         settle(3);
         `CHK(pin_oe, k[0] ? ~v : 7'h7f)
         `CHK(pin_level, v)
         reg_read(`GPCLIP_OFS_PIN_STATE, rd_val); `CHK(rd_val, {1'b0, v})
      end
      end_of_test();
   end
endmodule
